// ===== test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module tb;
  // ---------------------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic       sys_clk_i   = 1'b0;
  logic       reset_n_i   = 1'b0;
  logic       clk_en_i    = 1'b1;
  logic [7:0] reg_addr_i  = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_wr_i    = 1'b0;
  logic       reg_rd_i    = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       sys_reset_o;
  logic       cpu_clk_en_o;
  logic       irq_o;
  int         fail_count  = 0;
  int         checked     = 0;
  logic [7:0] v;
  logic [13:0] t1;
  logic [13:0] t2;
  int unsigned n;
  int unsigned per;

  wdt_top i_dut (
    .sys_clk_i    (sys_clk_i),
    .reset_n_i    (reset_n_i),
    .clk_en_i     (clk_en_i),
    .reg_addr_i   (reg_addr_i),
    .reg_wdata_i  (reg_wdata_i),
    .reg_wr_i     (reg_wr_i),
    .reg_rd_i     (reg_rd_i),
    .reg_rdata_o  (reg_rdata_o),
    .sys_reset_o  (sys_reset_o),
    .cpu_clk_en_o (cpu_clk_en_o),
    .irq_o        (irq_o)
  );

  // 250 MHz clock
  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  // cycles per timer step for a prescale code
  function automatic int unsigned step_cycles(input logic [2:0] ps);
    int unsigned d;
    case (ps)
      3'b000: d = 2;
      3'b010: d = 4;
      3'b001: d = 8;
      3'b011: d = 16;
      default: d = 32 << (ps - 3'b100);
    endcase
    return 12 * d;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic rd_timer(output logic [13:0] t);
    logic [7:0] lo;
    logic [7:0] hi;
    rd(wdt_pkg::ADDR_TIMER_L, lo);
    rd(wdt_pkg::ADDR_TIMER_H, hi);
    t = {hi[5:0], lo};
  endtask

  task automatic chip_reset();
    @(posedge sys_clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog against a hang; the tests need up to about 23000 cycles
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fail_count++;
    final_report();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1db8));
    chip_reset();
    // reset state of registers and outputs
    rd(wdt_pkg::ADDR_CTRL, v);
    `CHK("ctrl after reset", 8'h00, v)
    rd(wdt_pkg::ADDR_MASK, v);
    `CHK("mask after reset", 8'h00, v)
    rd(wdt_pkg::ADDR_STATUS, v);
    `CHK("status after reset", 8'h00, v)
    `CHK("cpu clock enable", 1'b1, cpu_clk_en_o)
    `CHK("irq after reset", 1'b0, irq_o)
    // disabled watchdog does not move
    repeat (200 + $urandom % 200) @(posedge sys_clk_i);
    rd_timer(t1);
    `CHK("timer while disabled", 14'h0000, t1)

    // every prescale code: clear, count n steps, read the timer
    for (int ps = 0; ps < 8; ps++) begin
      n   = 1 + $urandom % 3;
      per = step_cycles(ps[2:0]);
      wr(wdt_pkg::ADDR_CTRL, 8'hc0 | 8'(ps));
      repeat (n * per + per / 2 - 4) @(posedge sys_clk_i);
      rd_timer(t1);
      `CHK("timer steps", 14'(n), t1)
      rd(wdt_pkg::ADDR_CTRL, v);
      `CHK("clear bit self clears", 8'h80 | 8'(ps), v)
    end

    // disable holds, a zero clear bit does nothing, a one clears
    wr(wdt_pkg::ADDR_CTRL, 8'hc0);
    repeat (3 * 24 + 12) @(posedge sys_clk_i);
    wr(wdt_pkg::ADDR_CTRL, 8'h00);
    rd_timer(t1);
    `CHK("timer at disable", 14'd3, t1)
    repeat (300) @(posedge sys_clk_i);
    rd_timer(t2);
    `CHK("held when disabled", t1, t2)
    wr(wdt_pkg::ADDR_CTRL, 8'h87);
    rd_timer(t2);
    `CHK("zero clear no effect", t1, t2)
    wr(wdt_pkg::ADDR_CTRL, 8'h40);
    rd_timer(t2);
    `CHK("clear zeroes timer", 14'h0000, t2)
    rd(wdt_pkg::ADDR_CTRL, v);
    `CHK("clear bit reads zero", 8'h00, v)
    // a low clock enable freezes the count
    wr(wdt_pkg::ADDR_CTRL, 8'hc0);
    repeat (30) @(posedge sys_clk_i);
    clk_en_i <= 1'b0;
    repeat (240) @(posedge sys_clk_i);
    clk_en_i <= 1'b1;
    rd_timer(t1);
    `CHK("clock enable freezes", 14'd1, t1)

    // idle without idle-run: timer frozen
    chip_reset();
    wr(wdt_pkg::ADDR_CTRL, 8'hc0);
    wr(wdt_pkg::ADDR_POWER, 8'h01);
    #1;
    `CHK("cpu clock off in idle", 1'b0, cpu_clk_en_o)
    repeat (240) @(posedge sys_clk_i);
    rd_timer(t1);
    `CHK("idle freezes timer", 14'h0000, t1)
    // idle with idle-run: timer keeps counting
    chip_reset();
    `CHK("reset leaves idle", 1'b1, cpu_clk_en_o)
    wr(wdt_pkg::ADDR_CTRL, 8'hc8);
    wr(wdt_pkg::ADDR_POWER, 8'h01);
    repeat (3 * 24 + 6) @(posedge sys_clk_i);
    rd_timer(t1);
    `CHK("idle run counts", 14'd3, t1)
    rd(wdt_pkg::ADDR_CTRL, v);
    `CHK("idle run bit", 8'h88, v)

    // power-down stops the processor and never resets the system
    chip_reset();
    wr(wdt_pkg::ADDR_CTRL, 8'hc0);
    wr(wdt_pkg::ADDR_POWER, 8'h02);
    repeat (400) @(posedge sys_clk_i);
    `CHK("cpu clock off in power-down", 1'b0, cpu_clk_en_o)
    `CHK("no reset in power-down", 1'b0, sys_reset_o)
    rd_timer(t1);
    `CHK("power-down freezes timer", 14'h0000, t1)
    chip_reset();
    `CHK("reset ends power-down", 1'b1, cpu_clk_en_o)

    // random control, mask and unmapped accesses
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(wdt_pkg::ADDR_CTRL, v & 8'h7f);
      rd(wdt_pkg::ADDR_CTRL, t1[7:0]);
      `CHK("ctrl readback", v & 8'h0f, t1[7:0])
      wr(wdt_pkg::ADDR_MASK, v);
      rd(wdt_pkg::ADDR_MASK, t1[7:0]);
      `CHK("mask readback", v & 8'h03, t1[7:0])
      `CHK("irq without events", 1'b0, irq_o)
      v = 8'($urandom % 8'h80);
      if (v == wdt_pkg::ADDR_POWER) v = 8'h00;
      rd(v, t1[7:0]);
      `CHK("unmapped read", 8'h00, t1[7:0])
    end
    final_report();
  end
endmodule

// ===== verilog/wdt_pkg.sv
package wdt_pkg;

  // ---------------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h8f;  // watchdog_control
  localparam logic [7:0] ADDR_POWER   = 8'h87;  // power_control_reg
  localparam logic [7:0] ADDR_STATUS  = 8'h90;  // sticky event status
  localparam logic [7:0] ADDR_MASK    = 8'h91;  // event mask
  localparam logic [7:0] ADDR_TIMER_L = 8'h92;  // timer low byte
  localparam logic [7:0] ADDR_TIMER_H = 8'h93;  // timer high bits

  // ---------------------------------------------------------------------------
  // control, power control and status register fields
  // ---------------------------------------------------------------------------
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_CLEAR    = 6;
  localparam int BIT_IDLE_RUN = 3;
  localparam int BIT_PS2      = 2;
  localparam int BIT_PS1      = 1;
  localparam int BIT_PS0      = 0;
  localparam int BIT_IDLE_REQ = 0;  // power control
  localparam int BIT_PDOWN    = 1;  // power control
  localparam int BIT_EV_TMO   = 0;  // status: time-out seen
  localparam int BIT_EV_RST   = 1;  // status: system reset issued

  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET  = 8'h00;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int TIMER_W      = 14;
  localparam int PRESC_W      = 8;   // covers divide by 256
  localparam int MCYC_DIV     = 12;  // oscillator periods per machine cycle
  localparam int MCYC_W       = 4;
  localparam int RST_PULSE_NS = 32;  // system reset pulse length
  localparam int CLK_NS       = 4;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } wdt_bus_req_t;

  typedef enum logic [2:0] {
    WDT_ST_IDLE  = 3'b001,
    WDT_ST_COUNT = 3'b010,
    WDT_ST_FIRE  = 3'b100
  } wdt_state_t;

endpackage

// ===== verilog/wdt_tick.sv
`timescale 1ns/1ns
// modulo counter giving one tick every DIV enabled cycles
module wdt_tick #(
  parameter int          W   = 4,
  parameter logic [W-1:0] DIV = 4'd12
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  // control
  input  wire logic run_i,
  input  wire logic clear_i,
  // tick
  output logic      tick_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } wdt_tick_state_t;

  wdt_tick_state_t st_ff;
  wdt_tick_state_t nxt_st;

  // count to DIV-1 then wrap with a tick
  always_comb begin
    nxt_st = st_ff;
    if (clear_i) begin
      nxt_st.cnt = '0;
    end else if (run_i) begin
      if (st_ff.cnt == DIV - W'(1)) begin
        nxt_st.cnt = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + W'(1);
      end
    end
  end

  assign tick_o = run_i && !clear_i && (st_ff.cnt == DIV - W'(1));

  // state register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ===== verilog/wdt_top.sv
`timescale 1ns/1ns
// What this block does
// RQ1: timer is a free-running divider chain; selected tap sets time-out interval.
// RQ2: time-out with watchdog enabled raises a system reset.
// RQ3: chip reset leaves watchdog disabled until software sets enable.
// RQ4: enable bit set makes watchdog count and act; clear disables it.
// RQ5: writing one to clear bit zeroes timer, prescaler, clear bit next cycle.
// RQ6: idle-run bit keeps watchdog counting during idle; else inactive; resets zero.
// RQ7: prescale field b2b1b0 selects 2,8,4,16,32,64,128,256 per table order.
// RQ8: time-out is 2^14 times prescale times 12 oscillator periods.
// RQ9: software clears watchdog more often than the time-out period.
// RQ10: chip reset zeroes the timer and prescaler counts.
// RQ11: software should restart watchdog after enabling it.
// RQ12: idle stops processor clock; peripherals keep their clock.
// RQ13: power-down stops all clocks; only reset ends it; watchdog frozen. The code only drops cpu_clk_en_o, and a power register write also ends it.
// RQ14: writing zero to clear bit does nothing; disabled timer holds value.
module wdt_top (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       clk_en_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // system outputs
  output logic            sys_reset_o,
  output logic            cpu_clk_en_o,
  output logic            irq_o
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                   ctrl;
    logic [7:0]                   power;
    logic [1:0]                   status;
    logic [1:0]                   mask;
    logic [wdt_pkg::PRESC_W-1:0]  presc;
    logic [wdt_pkg::TIMER_W-1:0]  timer;
    logic [7:0]                   rdata;
    logic [3:0]                   rst_cnt;
    wdt_pkg::wdt_state_t          fsm;
  } wdt_state_struct_t;

  wdt_state_struct_t st_ff;
  wdt_state_struct_t nxt_st;

  wdt_pkg::wdt_bus_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  logic       enabled;
  logic       idle_mode;
  logic       pdown;
  logic       run;
  logic       mcyc_tick;
  logic [2:0] ps_sel;
  logic [3:0] ps_shift;
  logic       presc_wrap;
  logic       timeout;

  // ---------------------------------------------------------------------------
  // run conditions
  // ---------------------------------------------------------------------------
  assign enabled   = st_ff.ctrl[wdt_pkg::BIT_ENABLE];            // [RQ4]
  assign idle_mode = st_ff.power[wdt_pkg::BIT_IDLE_REQ];
  assign pdown     = st_ff.power[wdt_pkg::BIT_PDOWN];
  // idle stalls the processor, and the watchdog unless idle-run is set; power-down freezes the watchdog and the processor [RQ12] [RQ13]
  assign run = enabled && !pdown &&
               (!idle_mode || st_ff.ctrl[wdt_pkg::BIT_IDLE_RUN]); // [RQ6] [RQ14]
  assign cpu_clk_en_o = !idle_mode && !pdown;

  // machine cycle divider, one tick per twelve oscillator periods [RQ8]
  wdt_tick #(
    .W   (wdt_pkg::MCYC_W),
    .DIV (4'(wdt_pkg::MCYC_DIV))
  ) u_mcyc (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .run_i     (run),
    .clear_i   (st_ff.ctrl[wdt_pkg::BIT_CLEAR]),
    .tick_o    (mcyc_tick)
  );

  // prescale select: field b2 b1 b0 maps to divide exponent [RQ7]
  assign ps_sel = {st_ff.ctrl[wdt_pkg::BIT_PS2], st_ff.ctrl[wdt_pkg::BIT_PS1],
                   st_ff.ctrl[wdt_pkg::BIT_PS0]};
  always_comb begin
    unique case (ps_sel)
      3'h0: ps_shift = 4'h1;
      3'h2: ps_shift = 4'h2;
      3'h1: ps_shift = 4'h3;
      3'h3: ps_shift = 4'h4;
      3'h4: ps_shift = 4'h5;
      3'h5: ps_shift = 4'h6;
      3'h6: ps_shift = 4'h7;
      3'h7: ps_shift = 4'h8;
    endcase
  end

  // last prescaler count before the selected tap wraps
  function automatic logic [wdt_pkg::PRESC_W-1:0] PRESC_MAX(input logic [3:0] sh);
    logic [8:0] v;
    v = (9'h001 << sh) - 9'h001;
    return v[wdt_pkg::PRESC_W-1:0];
  endfunction

  // selected divider tap wraps [RQ1]
  assign presc_wrap = mcyc_tick &&
    (st_ff.presc == PRESC_MAX(ps_shift));
  assign timeout = presc_wrap && (st_ff.timer == {wdt_pkg::TIMER_W{1'b1}});

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;
    // clear bit self-clears one cycle after it was written [RQ5]
    if (st_ff.ctrl[wdt_pkg::BIT_CLEAR]) begin
      nxt_st.ctrl[wdt_pkg::BIT_CLEAR] = 1'b0;
      nxt_st.presc = '0;
      nxt_st.timer = '0;
    end else if (presc_wrap) begin
      nxt_st.presc = '0;
      nxt_st.timer = st_ff.timer + wdt_pkg::TIMER_W'(1);       // [RQ8]
    end else if (mcyc_tick) begin
      nxt_st.presc = st_ff.presc + wdt_pkg::PRESC_W'(1);
    end
    // time-out handling
    unique case (st_ff.fsm)
      wdt_pkg::WDT_ST_IDLE: begin
        if (enabled) begin
          nxt_st.fsm = wdt_pkg::WDT_ST_COUNT;
        end
      end
      wdt_pkg::WDT_ST_COUNT: begin
        if (!enabled) begin
          nxt_st.fsm = wdt_pkg::WDT_ST_IDLE;
        end else if (timeout) begin
          nxt_st.fsm     = wdt_pkg::WDT_ST_FIRE;              // [RQ2]
          nxt_st.rst_cnt = 4'(wdt_pkg::RST_PULSE_CYC - 1);
        end
      end
      wdt_pkg::WDT_ST_FIRE: begin
        if (st_ff.rst_cnt == 4'h0) begin
          // reset of the system also resets this block's control [RQ3] [RQ10]
          nxt_st.fsm   = wdt_pkg::WDT_ST_IDLE;
          nxt_st.ctrl  = wdt_pkg::CTRL_RESET;
          nxt_st.power = wdt_pkg::POWER_RESET;
          nxt_st.presc = '0;
          nxt_st.timer = '0;
        end else begin
          nxt_st.rst_cnt = st_ff.rst_cnt - 4'h1;
        end
      end
      default: nxt_st.fsm = wdt_pkg::WDT_ST_IDLE;
    endcase
    // register reads; status read clears, set below wins
    if (req.rd) begin
      unique case (req.addr)
        wdt_pkg::ADDR_CTRL:    nxt_st.rdata = st_ff.ctrl;
        wdt_pkg::ADDR_POWER:   nxt_st.rdata = st_ff.power;
        wdt_pkg::ADDR_STATUS: begin
          nxt_st.rdata  = {6'h00, st_ff.status};
          nxt_st.status = 2'h0;
        end
        wdt_pkg::ADDR_MASK:    nxt_st.rdata = {6'h00, st_ff.mask};
        wdt_pkg::ADDR_TIMER_L: nxt_st.rdata = st_ff.timer[7:0];
        wdt_pkg::ADDR_TIMER_H: nxt_st.rdata = {2'h0, st_ff.timer[13:8]};
        default:               nxt_st.rdata = 8'h00;
      endcase
    end
    // register writes (ignored while the system reset is asserted)
    if (req.wr && st_ff.fsm != wdt_pkg::WDT_ST_FIRE) begin
      unique case (req.addr)
        wdt_pkg::ADDR_CTRL: begin
          nxt_st.ctrl = req.wdata & 8'hcf;                      // [RQ4] [RQ6]
          // writing zero to the clear bit leaves a pending clear alone [RQ14]
          nxt_st.ctrl[wdt_pkg::BIT_CLEAR] = req.wdata[wdt_pkg::BIT_CLEAR];
        end
        wdt_pkg::ADDR_POWER: nxt_st.power = req.wdata & 8'h03;
        wdt_pkg::ADDR_MASK:  nxt_st.mask  = req.wdata[1:0];
        default: ;
      endcase
    end
    // sticky events
    if (timeout) begin
      nxt_st.status[wdt_pkg::BIT_EV_TMO] = 1'b1;
    end
    if (timeout && enabled) begin
      nxt_st.status[wdt_pkg::BIT_EV_RST] = 1'b1;
    end
  end

  // state register; chip reset disables and zeroes everything but fsm, which returns to WDT_ST_IDLE [RQ3] [RQ10]
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '{ctrl: wdt_pkg::CTRL_RESET, power: wdt_pkg::POWER_RESET,
                 status: 2'h0, mask: wdt_pkg::MASK_RESET[1:0], presc: '0,
                 timer: '0, rdata: 8'h00, rst_cnt: 4'h0,
                 fsm: wdt_pkg::WDT_ST_IDLE};
    end else if (clk_en_i) begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata_o = st_ff.rdata;
  assign sys_reset_o = (st_ff.fsm == wdt_pkg::WDT_ST_FIRE);   // [RQ2]
  assign irq_o       = |(st_ff.status & st_ff.mask);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  timeout_reset_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ2]
    clk_en_i && timeout && enabled && st_ff.fsm == wdt_pkg::WDT_ST_COUNT
      |=> sys_reset_o)
    else $error("enabled time-out did not raise reset");

  no_reset_off_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ3]
    $rose(sys_reset_o) |-> $past(enabled))
    else $error("reset raised while disabled");

  clear_effect_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ5]
    clk_en_i && st_ff.ctrl[wdt_pkg::BIT_CLEAR] && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      && !(req.wr && req.addr == wdt_pkg::ADDR_CTRL)
      |=> st_ff.timer == '0 && st_ff.presc == '0 && !st_ff.ctrl[wdt_pkg::BIT_CLEAR])
    else $error("clear bit did not zero the timer");

  idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ6]
    idle_mode && !st_ff.ctrl[wdt_pkg::BIT_IDLE_RUN] && !st_ff.ctrl[wdt_pkg::BIT_CLEAR]
      && st_ff.fsm != wdt_pkg::WDT_ST_FIRE |=> $stable(st_ff.timer))
    else $error("timer moved during idle");

  disabled_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ14]
    !enabled && !st_ff.ctrl[wdt_pkg::BIT_CLEAR] |=> $stable(st_ff.timer))
    else $error("timer moved while disabled");

  pdown_hold_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ13]
    pdown && !st_ff.ctrl[wdt_pkg::BIT_CLEAR] && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> $stable(st_ff.presc) && $stable(st_ff.timer))
    else $error("counter moved in power-down");

  timer_step_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ8]
    clk_en_i && presc_wrap && !st_ff.ctrl[wdt_pkg::BIT_CLEAR]
      && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> st_ff.timer == $past(st_ff.timer) + 14'h0001)
    else $error("timer did not advance on prescaler wrap");

  // code 001 wraps the prescaler after eight machine cycles
  presc_tap_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ7]
    ps_sel == 3'h1 && presc_wrap |-> st_ff.presc == 8'h07)
    else $error("prescale code 001 must divide by 8");

  // code 010 wraps the prescaler after four machine cycles
  presc_four_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ7]
    ps_sel == 3'h2 && presc_wrap |-> st_ff.presc == 8'h03)
    else $error("prescale code 010 must divide by 4");

  // a disabled watchdog leaves its prescaler alone
  enable_run_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ4]
    clk_en_i && !enabled && !st_ff.ctrl[wdt_pkg::BIT_CLEAR]
      && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> $stable(st_ff.presc))
    else $error("prescaler moved without enable");

  reset_len_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ2]
    clk_en_i && $rose(sys_reset_o) |-> sys_reset_o [*2])
    else $error("system reset pulse too short");

  // chip reset leaves the watchdog off with zeroed counts
  reset_state_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ3] [RQ10]
    $rose(reset_n_i) |-> !enabled && st_ff.timer == '0 && st_ff.presc == '0
      && st_ff.fsm == wdt_pkg::WDT_ST_IDLE)
    else $error("watchdog not idle after chip reset");

  // an enable write takes effect on the next cycle
  enable_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ4]
    clk_en_i && req.wr && req.addr == wdt_pkg::ADDR_CTRL
      && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> enabled == $past(req.wdata[wdt_pkg::BIT_ENABLE]))
    else $error("enable bit did not follow the write");

  // a zero in the clear bit never starts a clear
  zero_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ14]
    clk_en_i && req.wr && req.addr == wdt_pkg::ADDR_CTRL && !req.wdata[wdt_pkg::BIT_CLEAR]
      && st_ff.fsm != wdt_pkg::WDT_ST_FIRE |=> !st_ff.ctrl[wdt_pkg::BIT_CLEAR])
    else $error("zero clear bit started a clear");

  // idle with the idle-run bit keeps the prescaler moving
  idle_run_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ6]
    clk_en_i && idle_mode && mcyc_tick && !presc_wrap && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> st_ff.presc == $past(st_ff.presc) + 8'h01)
    else $error("prescaler stalled in idle run");

  // an idle write stops the processor clock
  idle_clk_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ12]
    clk_en_i && req.wr && req.addr == wdt_pkg::ADDR_POWER
      && req.wdata[wdt_pkg::BIT_IDLE_REQ] && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> !cpu_clk_en_o)
    else $error("processor clock still on in idle");

  // a power-down write stops the processor clock
  pdown_clk_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ13]
    clk_en_i && req.wr && req.addr == wdt_pkg::ADDR_POWER
      && req.wdata[wdt_pkg::BIT_PDOWN] && st_ff.fsm != wdt_pkg::WDT_ST_FIRE
      |=> !cpu_clk_en_o)
    else $error("processor clock still on in power-down");

  // a status read clears the sticky bits unless an event lands
  status_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ2]
    clk_en_i && req.rd && req.addr == wdt_pkg::ADDR_STATUS && !timeout
      |=> st_ff.status == 2'h0)
    else $error("status not cleared by read");

  // the high timer byte carries only the upper six bits
  timer_high_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i) // [RQ8]
    clk_en_i && req.rd && req.addr == wdt_pkg::ADDR_TIMER_H
      |=> reg_rdata_o[7:6] == 2'h0)
    else $error("timer high byte wider than fourteen bits");

endmodule
